/* hdl/pslh_cfg.svh */
// Constants of the phase-shedding and loop-hold configuration bank.
// Assumes a 100 MHz core clock; included by the bank and the testbench.
`ifndef PSLH_CFG_SVH
`define PSLH_CFG_SVH

// Command codes
`define PSLH_OFS_SHED_LEVEL_MID   8'hc6
`define PSLH_OFS_SHED_TIMING_HYS  8'hc7
`define PSLH_OFS_DROOP_OFFSET     8'hc9
`define PSLH_OFS_DC_LOOP_HOLD     8'hcb
`define PSLH_OFS_SHED_EXIT        8'hcc
`define PSLH_OFS_OSR_TIMING       8'hcd
`define PSLH_OFS_SLOPE_BLANK      8'hce
`define PSLH_OFS_MEM_SUPPLY       8'hcf

// Writable-bit masks; clear bits are reserved
`define PSLH_MASK_SHED_LEVEL_MID  16'hffff
`define PSLH_MASK_SHED_TIMING_HYS 16'h7f0f
`define PSLH_MASK_DROOP_OFFSET    16'h003f
`define PSLH_MASK_DC_LOOP_HOLD    16'hffff
`define PSLH_MASK_SHED_EXIT       16'h01ff
`define PSLH_MASK_OSR_TIMING      16'h1fff
`define PSLH_MASK_SLOPE_BLANK     16'h0fff
`define PSLH_MASK_MEM_SUPPLY      16'h0003

// Reset values
`define PSLH_RST_SHED_LEVEL_MID   16'h0000
`define PSLH_RST_SHED_TIMING_HYS  16'h0000
`define PSLH_RST_DROOP_OFFSET     16'h0000
`define PSLH_RST_DC_LOOP_HOLD     16'h0000
`define PSLH_RST_SHED_EXIT        16'h0000
`define PSLH_RST_OSR_TIMING       16'h0000
`define PSLH_RST_SLOPE_BLANK      16'h0000
`define PSLH_RST_MEM_SUPPLY       16'h0000

// Field positions
`define PSLH_BIT_ONE_BY_ONE       8
`define PSLH_BIT_PERIOD_ADD       15
`define PSLH_BIT_UNDERVOLT_ADD    14
`define PSLH_BIT_FREQ_HOLD_EN     6
`define PSLH_BIT_PHASE_HOLD_EN    5
`define PSLH_BIT_WINDOW_HOLD_EN   4
`define PSLH_BIT_LOW_EXIT_EN      2
`define PSLH_BIT_FREQ_EXIT_EN     1
`define PSLH_BIT_OC_EXIT_EN       0
`define PSLH_BIT_DROOP_SIGN       5
`define PSLH_BIT_R2_REJECT        1
`define PSLH_BIT_R2_HALF          0

// Timing
`define PSLH_CLK_NS               10
`define PSLH_US_NS                1000
`define PSLH_STEP_US              1
`define PSLH_FULL_US              20
`define PSLH_HOLD_US              200
`define PSLH_HOLD_OFS_US          100
`define PSLH_PERIOD_LSB_NS        16'd80

// Phase counts; FULL stands for every fitted phase
`define PSLH_PH_TWO               3'h2
`define PSLH_PH_THREE             3'h3
`define PSLH_PH_FULL              3'h4

// Droop offset weights in 10 nA units
`define PSLH_DROOP_W4             13'd1300
`define PSLH_DROOP_W3             13'd648
`define PSLH_DROOP_W2             13'd324
`define PSLH_DROOP_W1             13'd162
`define PSLH_DROOP_W0             13'd81

`endif

/* hdl/pslh_pkg.sv */
// Types of the phase-shedding and loop-hold configuration bank.
// Assumes pslh_cfg.svh is on the include path.
`default_nettype none
package pslh_pkg;
    typedef enum logic {PSLH_NORMAL, PSLH_EXIT_HOLD} pslh_mode_t;
    typedef logic [19:0] pslh_cnt_t;
endpackage
`default_nettype wire

/* hdl/pslh_bank.sv */
// Rail 1 shedding, droop offset, loop hold and Rail 2 option bank.
// Assumes a serial-bus decoder drives the command port on clk_i and
// event pins arrive asynchronously; analog loop sits outside.
//
// Contract
// RULE1: thresholds apply only while shedding mode is 1x
// RULE2: bits 15:8 threshold to three phases, 1 A
// RULE3: bits 7:0 threshold to two phases, 1 A
// RULE4: reserved bits ignore writes, read zero
// RULE5: bit 8 selects immediate or one-by-one shedding
// RULE6: bits 14:9 step interval, 1 us
// RULE7: bits 3:0 shed hysteresis, 1 A
// RULE8: droop offset sign-magnitude, weighted bits
// RULE9: bit 15 period-triggered add sequence
// RULE10: bit 14 undervolt-triggered add sequence
// RULE11: period window holds DC and balance loops
// RULE12: bits 6:4 enable DC hold conditions
// RULE13: hold time field times 200 plus 100 us
// RULE14: full-phase minimum after exit, 20 us steps
// RULE15: bits 2:0 enable shedding exit triggers
// RULE16: reduction off-time and blanking fields
// RULE17: slope reset time when mode bit clear
// RULE18: PWM blanking between consecutive phases
// RULE19: Rail 2 rejects processor commands when set
// RULE20: Rail 2 target half of Rail 1
// RULE21: DC hold lasts minimum after last condition
`include "pslh_cfg.svh"
`default_nettype none

module pslh_bank
    import pslh_pkg::*;
#(
    parameter int unsigned CYC_PER_US = `PSLH_US_NS / `PSLH_CLK_NS
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // Command port
    input  wire logic [7:0]         cmd_code_i,
    input  wire logic               wr_en_i,
    input  wire logic [15:0]        wr_data_i,
    output logic      [15:0]        rd_data_o,
    // Regulator state, same clock
    input  wire logic [1:0]         shed_mode_i,
    input  wire logic [7:0]         load_current_i,
    input  wire logic [15:0]        period_err_ns_i,
    input  wire logic               dcm_i,
    input  wire logic               slope_mode_i,
    input  wire logic [7:0]         rail1_vid_i,
    input  wire logic [7:0]         rail2_vid_i,
    // Event pins, asynchronous
    input  wire logic               fb_below_low_i,
    input  wire logic               freq_limit_i,
    input  wire logic               phase_oc_i,
    input  wire logic               fb_out_window_i,
    // Shedding and loop control
    output logic      [2:0]         phase_count_o,
    output logic                    dc_hold_o,
    output logic                    cb_hold_o,
    output logic                    period_add_direct_o,
    output logic                    undervolt_add_direct_o,
    output logic signed [12:0]      droop_offset_o,
    // Timing fields
    output logic      [5:0]         osr_min_off_o,
    output logic      [6:0]         osr_blank_o,
    output logic      [5:0]         slope_reset_o,
    output logic      [5:0]         pwm_blank_o,
    // Rail 2
    output logic                    rail2_reject_o,
    output logic      [7:0]         rail2_target_o
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0]        lvl;
        logic [15:0]        shset;
        logic [15:0]        droop;
        logic [15:0]        dcl;
        logic [15:0]        exitc;
        logic [15:0]        overshoot_reduction;
        logic [15:0]        blank;
        logic [15:0]        ddr;
        logic [2:0]         s_low;
        logic [2:0]         s_fs;
        logic [2:0]         s_oc;
        logic [2:0]         s_win;
        logic               f_low;
        logic               f_fs;
        logic               f_oc;
        logic               f_win;
        pslh_mode_t         mode;
        logic [2:0]         phases;
        pslh_cnt_t          step_cnt;
        pslh_cnt_t          full_cnt;
        pslh_cnt_t          hold_cnt;
        logic               dc_hold;
        logic               cb_hold;
        logic signed [12:0] droop_out;
        logic [15:0]        rd;
        logic [7:0]         r2_target;
        logic [5:0]         slope_rst;
    } pslh_state_t;

    pslh_state_t st;
    pslh_state_t next_st;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] shed_target(
        input logic [7:0]  cur,
        input logic [15:0] lvl
    );
        if (cur < lvl[7:0])
            return `PSLH_PH_TWO;    // RULE3
        if (cur < lvl[15:8])
            return `PSLH_PH_THREE;  // RULE2
        return `PSLH_PH_FULL;
    endfunction

    function automatic pslh_cnt_t us_cycles(input logic [31:0] us);
        logic [31:0] prod;
        prod = us * CYC_PER_US;
        return prod[19:0];
    endfunction

    // Second and third stage agreeing marks a settled level
    function automatic logic settle(input logic [2:0] s, input logic f);
        return (s[1] == s[2]) ? s[2] : f;
    endfunction

    function automatic logic signed [12:0] droop_value(
        input logic [5:0] c
    );
        logic [12:0] mag;
        mag = (c[4] ? `PSLH_DROOP_W4 : 13'h0)
            + (c[3] ? `PSLH_DROOP_W3 : 13'h0)
            + (c[2] ? `PSLH_DROOP_W2 : 13'h0)
            + (c[1] ? `PSLH_DROOP_W1 : 13'h0)
            + (c[0] ? `PSLH_DROOP_W0 : 13'h0);
        return c[`PSLH_BIT_DROOP_SIGN] ? -$signed(mag)
                                        : $signed(mag); // RULE8
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic        aps_en;
    logic [2:0]  tgt_dn;
    logic [2:0]  tgt_up;
    logic [7:0]  cur_hys;
    logic        exit_evt;
    logic        prd_ok;
    logic        hold_cond;
    logic [15:0] win_ns;
    logic [15:0] wmask;

    always_comb begin
        next_st = st;
        // Synchronisers: stage 0 feeds stage 1 only
        next_st.s_low = {st.s_low[1:0], fb_below_low_i};
        next_st.s_fs  = {st.s_fs[1:0], freq_limit_i};
        next_st.s_oc  = {st.s_oc[1:0], phase_oc_i};
        next_st.s_win = {st.s_win[1:0], fb_out_window_i};
        next_st.f_low = settle(st.s_low, st.f_low);
        next_st.f_fs  = settle(st.s_fs, st.f_fs);
        next_st.f_oc  = settle(st.s_oc, st.f_oc);
        next_st.f_win = settle(st.s_win, st.f_win);
        // Register writes; reserved bits never store
        unique case (cmd_code_i)
            `PSLH_OFS_SHED_LEVEL_MID:  wmask = `PSLH_MASK_SHED_LEVEL_MID;
            `PSLH_OFS_SHED_TIMING_HYS: wmask = `PSLH_MASK_SHED_TIMING_HYS;
            `PSLH_OFS_DROOP_OFFSET:    wmask = `PSLH_MASK_DROOP_OFFSET;
            `PSLH_OFS_DC_LOOP_HOLD:    wmask = `PSLH_MASK_DC_LOOP_HOLD;
            `PSLH_OFS_SHED_EXIT:       wmask = `PSLH_MASK_SHED_EXIT;
            `PSLH_OFS_OSR_TIMING:      wmask = `PSLH_MASK_OSR_TIMING;
            `PSLH_OFS_SLOPE_BLANK:     wmask = `PSLH_MASK_SLOPE_BLANK;
            `PSLH_OFS_MEM_SUPPLY:      wmask = `PSLH_MASK_MEM_SUPPLY;
            default:                   wmask = 16'h0000;
        endcase
        if (wr_en_i) begin
            unique case (cmd_code_i)
                `PSLH_OFS_SHED_LEVEL_MID:  next_st.lvl   = wr_data_i & wmask;
                `PSLH_OFS_SHED_TIMING_HYS: next_st.shset = wr_data_i & wmask;
                `PSLH_OFS_DROOP_OFFSET:    next_st.droop = wr_data_i & wmask;
                `PSLH_OFS_DC_LOOP_HOLD:    next_st.dcl   = wr_data_i & wmask;
                `PSLH_OFS_SHED_EXIT:       next_st.exitc = wr_data_i & wmask;
                `PSLH_OFS_OSR_TIMING:      next_st.overshoot_reduction   = wr_data_i & wmask;
                `PSLH_OFS_SLOPE_BLANK:     next_st.blank = wr_data_i & wmask;
                `PSLH_OFS_MEM_SUPPLY:      next_st.ddr   = wr_data_i & wmask;
                default: ;
            endcase
        end // RULE4

        // Reads show stored bits; unmapped codes read zero
        unique case (cmd_code_i)
            `PSLH_OFS_SHED_LEVEL_MID:  next_st.rd = st.lvl;
            `PSLH_OFS_SHED_TIMING_HYS: next_st.rd = st.shset;
            `PSLH_OFS_DROOP_OFFSET:    next_st.rd = st.droop;
            `PSLH_OFS_DC_LOOP_HOLD:    next_st.rd = st.dcl;
            `PSLH_OFS_SHED_EXIT:       next_st.rd = st.exitc;
            `PSLH_OFS_OSR_TIMING:      next_st.rd = st.overshoot_reduction;
            `PSLH_OFS_SLOPE_BLANK:     next_st.rd = st.blank;
            `PSLH_OFS_MEM_SUPPLY:      next_st.rd = st.ddr;
            default:                   next_st.rd = 16'h0000;
        endcase

        // Shedding target with hysteresis on the way back up
        aps_en  = shed_mode_i[1]; // RULE1
        cur_hys = (load_current_i > {4'h0, st.shset[3:0]})
                ? load_current_i - {4'h0, st.shset[3:0]} : 8'h00; // RULE7
        tgt_dn  = shed_target(load_current_i, st.lvl);
        tgt_up  = shed_target(cur_hys, st.lvl);
        exit_evt = (st.exitc[`PSLH_BIT_LOW_EXIT_EN] && st.f_low)
                 || (st.exitc[`PSLH_BIT_FREQ_EXIT_EN] && st.f_fs)
                 || (st.exitc[`PSLH_BIT_OC_EXIT_EN] && st.f_oc); // RULE15
        if (st.step_cnt != '0)
            next_st.step_cnt = st.step_cnt - 20'h1;
        if (st.full_cnt != '0)
            next_st.full_cnt = st.full_cnt - 20'h1;
        if (!aps_en) begin
            next_st.phases = `PSLH_PH_FULL; // RULE1
            next_st.mode   = PSLH_NORMAL;
        end else if (exit_evt) begin
            // A fresh trigger during the hold restarts the minimum
            next_st.phases   = `PSLH_PH_FULL;
            next_st.mode     = PSLH_EXIT_HOLD;
            next_st.full_cnt = us_cycles(32'(st.exitc[8:3])
                                         * `PSLH_FULL_US); // RULE14
        end else begin
            unique case (st.mode)
                PSLH_EXIT_HOLD: begin
                    next_st.phases = `PSLH_PH_FULL;
                    if (st.full_cnt == '0)
                        next_st.mode = PSLH_NORMAL;
                end
                PSLH_NORMAL: begin
                    if (tgt_up > st.phases) begin
                        next_st.phases = tgt_up;
                    end else if (tgt_dn < st.phases) begin
                        if (!st.shset[`PSLH_BIT_ONE_BY_ONE]) begin
                            next_st.phases = tgt_dn; // RULE5
                        end else if (st.step_cnt == '0) begin
                            next_st.phases   = st.phases - 3'h1; // RULE5
                            next_st.step_cnt = us_cycles(
                                32'(st.shset[14:9]) * `PSLH_STEP_US);
                        end // RULE6
                    end
                end
            endcase
        end

        // Loop hold; only the period window is gated off in discontinuous conduction
        win_ns  = {9'h000, st.dcl[13:7]} * `PSLH_PERIOD_LSB_NS;
        prd_ok  = st.dcl[`PSLH_BIT_FREQ_HOLD_EN] && !dcm_i
                && (period_err_ns_i <= win_ns); // RULE11
        hold_cond = prd_ok
            || (st.dcl[`PSLH_BIT_PHASE_HOLD_EN]
                && (next_st.phases != st.phases))
            || (st.dcl[`PSLH_BIT_WINDOW_HOLD_EN] && st.f_win); // RULE12
        next_st.cb_hold = prd_ok; // RULE11
        if (hold_cond)
            next_st.hold_cnt = us_cycles(32'(st.dcl[3:0]) * `PSLH_HOLD_US
                                         + `PSLH_HOLD_OFS_US); // RULE13
        else if (st.hold_cnt != '0)
            next_st.hold_cnt = st.hold_cnt - 20'h1;
        next_st.dc_hold = hold_cond || (st.hold_cnt > 20'h1); // RULE21
        next_st.droop_out = droop_value(st.droop[5:0]);
        next_st.slope_rst = slope_mode_i ? 6'h00 : st.blank[11:6]; // RULE17
        next_st.r2_target = st.ddr[`PSLH_BIT_R2_HALF]
                          ? {1'b0, rail1_vid_i[7:1]} : rail2_vid_i; // RULE20
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st       <= '0;
            st.lvl   <= `PSLH_RST_SHED_LEVEL_MID;
            st.shset <= `PSLH_RST_SHED_TIMING_HYS;
            st.droop <= `PSLH_RST_DROOP_OFFSET;
            st.dcl   <= `PSLH_RST_DC_LOOP_HOLD;
            st.exitc <= `PSLH_RST_SHED_EXIT;
            st.overshoot_reduction   <= `PSLH_RST_OSR_TIMING;
            st.blank <= `PSLH_RST_SLOPE_BLANK;
            st.ddr   <= `PSLH_RST_MEM_SUPPLY;
            st.mode  <= PSLH_NORMAL;
            st.phases <= `PSLH_PH_FULL;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field outputs; the slope reset only counts with the mode bit clear
    assign rd_data_o              = st.rd;
    assign phase_count_o          = st.phases;
    assign dc_hold_o              = st.dc_hold;
    assign cb_hold_o              = st.cb_hold;
    assign period_add_direct_o    = st.dcl[`PSLH_BIT_PERIOD_ADD]; // RULE9
    assign undervolt_add_direct_o = st.dcl[`PSLH_BIT_UNDERVOLT_ADD]; // RULE10
    assign droop_offset_o         = st.droop_out;
    assign osr_min_off_o          = st.overshoot_reduction[12:7]; // RULE16
    assign osr_blank_o            = st.overshoot_reduction[6:0]; // RULE16
    assign slope_reset_o          = st.slope_rst;
    assign pwm_blank_o            = st.blank[5:0]; // RULE18
    assign rail2_reject_o         = st.ddr[`PSLH_BIT_R2_REJECT]; // RULE19
    assign rail2_target_o         = st.r2_target;

    ////////////////////////////////////////////////////////////////////
    property p_resv_zero; // RULE4
        @(posedge clk_i) disable iff (!resetn_i)
        ((st.shset & ~`PSLH_MASK_SHED_TIMING_HYS) == 16'h0)
        && ((st.exitc & ~`PSLH_MASK_SHED_EXIT) == 16'h0)
        && ((st.ddr & ~`PSLH_MASK_MEM_SUPPLY) == 16'h0);
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved bit stored");
    property p_aps_off_full; // RULE1
        @(posedge clk_i) disable iff (!resetn_i)
        !shed_mode_i[1] |=> phase_count_o == `PSLH_PH_FULL;
    endproperty
    a_aps_off_full: assert property (p_aps_off_full)
        else $error("phases shed while shedding disabled");
    property p_one_step; // RULE5
        @(posedge clk_i) disable iff (!resetn_i)
        $past(st.shset[`PSLH_BIT_ONE_BY_ONE]) && st.mode == PSLH_NORMAL
        && phase_count_o < $past(phase_count_o)
        |-> phase_count_o + 3'h1 == $past(phase_count_o);
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("more than one phase dropped at once");
    property p_cb_no_dcm; // RULE11
        @(posedge clk_i) disable iff (!resetn_i)
        cb_hold_o |-> !$past(dcm_i);
    endproperty
    a_cb_no_dcm: assert property (p_cb_no_dcm)
        else $error("balance hold in discontinuous mode");
    property p_half_track; // RULE20
        @(posedge clk_i) disable iff (!resetn_i)
        st.ddr[`PSLH_BIT_R2_HALF]
        |=> rail2_target_o == {1'b0, $past(rail1_vid_i[7:1])};
    endproperty
    a_half_track: assert property (p_half_track)
        else $error("rail 2 not at half of rail 1");
    property p_reject_wr; // RULE19
        @(posedge clk_i) disable iff (!resetn_i)
        wr_en_i && cmd_code_i == `PSLH_OFS_MEM_SUPPLY
        |=> rail2_reject_o == $past(wr_data_i[`PSLH_BIT_R2_REJECT]);
    endproperty
    a_reject_wr: assert property (p_reject_wr)
        else $error("reject bit did not follow write");
    property p_exit_full; // RULE15
        @(posedge clk_i) disable iff (!resetn_i)
        shed_mode_i[1] && st.f_oc && st.exitc[`PSLH_BIT_OC_EXIT_EN]
        |=> phase_count_o == `PSLH_PH_FULL && st.mode == PSLH_EXIT_HOLD;
    endproperty
    a_exit_full: assert property (p_exit_full)
        else $error("overcurrent exit did not restore all phases");
    property p_hold_min; // RULE21
        @(posedge clk_i) disable iff (!resetn_i)
        $fell(dc_hold_o) |-> $past(st.hold_cnt) <= 20'h1;
    endproperty
    a_hold_min: assert property (p_hold_min)
        else $error("loop hold released early");
    property p_droop_sign; // RULE8
        @(posedge clk_i) disable iff (!resetn_i)
        st.droop[5] && st.droop[4:0] != 5'h0 |=> droop_offset_o < 0;
    endproperty
    a_droop_sign: assert property (p_droop_sign)
        else $error("negative droop offset not negative");

endmodule

`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the shedding and loop-hold configuration bank.
// Assumes pslh_cfg.svh on the include path; the bank runs 1 cycle per us.
`include "pslh_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk_i    = 1'b0;
    logic               resetn_i = 1'b0;
    logic [7:0]         cmd      = 8'h00;
    logic               wen      = 1'b0;
    logic [15:0]        wd       = 16'h0000;
    logic [1:0]         smode    = 2'b00;
    logic [7:0]         load     = 8'h00;
    logic [15:0]        perr     = 16'h0000;
    logic               dcm      = 1'b0;
    logic               slm      = 1'b0;
    logic [7:0]         v1       = 8'h00;
    logic [7:0]         v2       = 8'h00;
    // Event pins: 0 overcurrent, 1 freq limit, 2 low window, 3 out window
    logic [3:0]         ev       = 4'h0;
    logic [15:0]        rdd;
    logic [2:0]         pc;
    logic               dch, cbh, pad, uad, rrej;
    logic signed [12:0] droop;
    logic [5:0]         omin, slr, pwb;
    logic [6:0]         obl;
    logic [7:0]         r2t;
    int                 bad_count   = 0;
    int                 check_count = 0;
    int                 cyc         = 0;
    // Last entry is an unmapped code, which reads zero
    logic [7:0]  cds [9] = '{8'hc6, 8'hc7, 8'hc9, 8'hcb, 8'hcc, 8'hcd,
                             8'hce, 8'hcf, 8'hc8};
    logic [15:0] mk [9] = '{`PSLH_MASK_SHED_LEVEL_MID,
        `PSLH_MASK_SHED_TIMING_HYS, `PSLH_MASK_DROOP_OFFSET,
        `PSLH_MASK_DC_LOOP_HOLD, `PSLH_MASK_SHED_EXIT,
        `PSLH_MASK_OSR_TIMING, `PSLH_MASK_SLOPE_BLANK,
        `PSLH_MASK_MEM_SUPPLY, 16'h0000};

    always #5 clk_i = ~clk_i;

    pslh_bank #(.CYC_PER_US(1)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_code_i(cmd),
        .wr_en_i(wen), .wr_data_i(wd), .rd_data_o(rdd),
        .shed_mode_i(smode), .load_current_i(load),
        .period_err_ns_i(perr), .dcm_i(dcm), .slope_mode_i(slm),
        .rail1_vid_i(v1), .rail2_vid_i(v2), .fb_below_low_i(ev[2]),
        .freq_limit_i(ev[1]), .phase_oc_i(ev[0]),
        .fb_out_window_i(ev[3]), .phase_count_o(pc), .dc_hold_o(dch),
        .cb_hold_o(cbh), .period_add_direct_o(pad),
        .undervolt_add_direct_o(uad), .droop_offset_o(droop),
        .osr_min_off_o(omin), .osr_blank_o(obl), .slope_reset_o(slr),
        .pwm_blank_o(pwb), .rail2_reject_o(rrej), .rail2_target_o(r2t));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        cmd <= c;
        wen <= 1'b1;
        wd  <= d;
        @(posedge clk_i);
        wen <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        @(posedge clk_i);
        cmd <= c;
        @(posedge clk_i);
        #1 q = rdd;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Waits a bounded time for a phase count, then compares it
    task automatic wpc(input logic [2:0] e, input int lim, output int n);
        n = 0;
        while (pc !== e && n < lim) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(16'(pc), 16'(e));
    endtask

    // Offset in 10 nA units: magnitude weights, bit 5 negates
    function automatic logic [15:0] droop_m(input logic [5:0] c);
        int w [5] = '{81, 162, 324, 648, 1300};
        int m = 0;
        for (int i = 0; i < 5; i++) if (c[i]) m += w[i];
        return 16'(c[5] ? -m : m);
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs a few thousand cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] q;
        logic [15:0] d;
        int          n;
        void'($urandom(32'h16f8));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(cds[i], q);
            chk(q, 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 9; i++) begin
                d = (k == 0) ? 16'hffff : 16'($urandom);
                wr(cds[i], d);
                rd(cds[i], q);
                chk(q, d & mk[i]);
            end
        end
        $display("register test done");
        for (int k = 0; k < 8; k++) begin
            d = 16'($urandom);
            for (int i = 2; i < 8; i++) wr(cds[i], d);
            slm <= d[2];
            v1  <= d[15:8];
            v2  <= d[7:0];
            wt(3);
            chk(16'(pad), 16'(d[15]));
            chk(16'(uad), 16'(d[14]));
            chk(16'(omin), 16'(d[12:7]));
            chk(16'(obl), 16'(d[6:0]));
            chk(16'(slr), slm ? 16'h0000 : 16'(d[11:6]));
            chk(16'(pwb), 16'(d[5:0]));
            chk(16'(rrej), 16'(d[1]));
            chk(16'(r2t), 16'(d[0] ? (v1 >> 1) : v2));
            chk(16'(droop), droop_m(d[5:0]));
        end
        $display("field test done");
        wr(8'hcb, 16'h0000);
        wr(8'hcc, 16'h0000);
        wr(8'hc6, {8'd40, 8'd20});
        wr(8'hc7, 16'h0005);
        load  <= 8'd10;
        smode <= 2'b01;
        wt(20);
        chk(16'(pc), 16'h0004);
        @(posedge clk_i) smode <= 2'b10;
        wpc(3'h2, 4, n);
        @(posedge clk_i) load <= 8'd22;
        wt(20);
        chk(16'(pc), 16'h0002);
        @(posedge clk_i) load <= 8'd26;
        wpc(3'h3, 10, n);
        @(posedge clk_i) load <= 8'd50;
        wpc(3'h4, 10, n);
        @(posedge clk_i) load <= 8'd39;
        wpc(3'h3, 10, n);
        @(posedge clk_i) load <= 8'd19;
        wpc(3'h2, 10, n);
        @(posedge clk_i) load <= 8'd50;
        wpc(3'h4, 10, n);
        wr(8'hc7, 16'h2905);
        @(posedge clk_i) load <= 8'd10;
        wpc(3'h3, 30, n);
        wpc(3'h2, 40, n);
        chk(16'(n >= 18 && n <= 22), 16'h0001);
        wr(8'hc7, 16'h0005);
        $display("shedding test done");
        for (int b = 0; b < 3; b++) begin
            wr(8'hcc, 16'h0010);
            ev[b] <= 1'b1;
            wt(10);
            chk(16'(pc), 16'h0002);
            @(posedge clk_i) ev[b] <= 1'b0;
            wr(8'hcc, 16'h0010 | (16'h0001 << b));
            ev[b] <= 1'b1;
            wpc(3'h4, 8, n);
            @(posedge clk_i) ev[b] <= 1'b0;
            wt(25);
            chk(16'(pc), 16'h0004);
            wpc(3'h2, 40, n);
        end
        $display("exit test done");
        wr(8'hcb, 16'h0000);
        perr <= 16'd1000;
        ev[3] <= 1'b1;
        // Let any hold armed by the random field writes run out first
        wt(3100);
        chk(16'(dch), 16'h0000);
        @(posedge clk_i) ev[3] <= 1'b0;
        wr(8'hcb, 16'h0010);
        ev[3] <= 1'b1;
        wt(8);
        chk(16'(dch), 16'h0001);
        @(posedge clk_i) ev[3] <= 1'b0;
        n = 0;
        while (dch === 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(16'(n >= 98 && n <= 110), 16'h0001);
        wr(8'hcb, 16'h0140);
        perr <= 16'd161;
        wt(10);
        chk(16'(cbh), 16'h0000);
        @(posedge clk_i) perr <= 16'd160;
        dcm <= 1'b1;
        wt(10);
        chk(16'(cbh), 16'h0000);
        @(posedge clk_i) dcm <= 1'b0;
        wt(4);
        chk(16'(cbh), 16'h0001);
        chk(16'(dch), 16'h0001);
        wr(8'hcb, 16'h0021);
        wt(110);
        chk(16'(dch), 16'h0000);
        @(posedge clk_i) load <= 8'd50;
        wt(3);
        chk(16'(dch), 16'h0001);
        n = 0;
        while (dch === 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(16'(n >= 295 && n <= 305), 16'h0001);
        $display("loop hold test done");
        test_done();
    end
endmodule
`default_nettype wire
